//--- rtl/wbcw_pkg.sv
// Contract
// (RL1) Warm boot resets config logic, keeps this block
// (RL2) Warm boot loads from start address register
// (RL3) Default start: zero, or all ones descending
// (RL4) Caller sends dummy, sync, address, then command
// (RL5) Decode headers for address, command, timer writes
// (RL6) Low nibble ones warm boot; 0x11 reload; 0xD release
// (RL7) Warm boot: init, done low; clear; load
// (RL8) Revision select follows start address on warm boot
// (RL9) Serial flash gets 24-bit address shifted out
// (RL10) Revision select pins actively driven on reboot
// (RL11) Warm boot during fallback ignored but recorded
// (RL12) History is a two-entry shift register
// (RL13) Entry carries valid plus six status flags
// (RL14) First clean load: entry zero valid only
// (RL15) Failed warm image then fallback recorded correctly
// (RL16) Watchdog tick is 50 MHz over 256; 24 bits
// (RL17) Watchdog timeout loads fallback image
// (RL18) Timer write enables; fallback disables until warm boot
// (RL19) Config monitor expiry before startup end fails
// (RL20) User logic reloads watchdog before it expires
// (RL21) Shutdown disables the watchdog
// (RL22) Config monitor timeout covers whole load
// (RL23) Config error: reset, drive revision select zero
// (RL24) Fallback failure halts with init, done low
// (RL25) Reload restores count, keeps monitor mode
// (RL26) Words ignored until sync, again after release
package wbcw_pkg;
  localparam logic [31:0] SYNC_WORD      = 32'haa995566;
  localparam logic [31:0] HDR_START_ADDR = 32'h30020001;
  localparam logic [31:0] HDR_COMMAND    = 32'h30008001;
  localparam logic [31:0] HDR_TIMER      = 32'h30022001;
  localparam logic [3:0]  CMD_WARM_NIB   = 4'hf;
  localparam logic [31:0] CMD_RELOAD     = 32'h00000011;
  localparam logic [31:0] CMD_RELEASE    = 32'h0000000d;
  localparam int          ADDR_W         = 26;
  localparam int          SPI_ADDR_W     = 24;
  localparam int          WD_W           = 24;
  localparam int          RS_HI          = 31;
  localparam int          RS_LO          = 30;
  localparam int          TMR_USR_BIT    = 31;
  localparam int          TMR_CFG_BIT    = 30;
  localparam logic [1:0]  RS_FALLBACK    = 2'h0;
  localparam logic [25:0] ADDR_ASCEND    = 26'h0000000;
  localparam logic [25:0] ADDR_DESCEND   = 26'h3ffffff;
  localparam int          CLK_FREQ_MHZ   = 100;
  localparam int          WD_SRC_MHZ     = 50;
  localparam int          WD_PREDIV      = 256;
  localparam int          WD_TICK_CYCLES = WD_PREDIV * CLK_FREQ_MHZ / WD_SRC_MHZ;
  localparam int          TICK_W         = $clog2(WD_TICK_CYCLES);

  typedef enum logic [2:0] {
    MODE_MSERIAL, MODE_SPI, MODE_PAR_ASC, MODE_PAR_DESC,
    MODE_MPARALLEL, MODE_JTAG, MODE_SPARALLEL, MODE_SSERIAL
  } wbcw_mode_t;
  typedef enum logic [2:0] {PH_CLEAR, PH_SHIFT, PH_LOAD, PH_RUN, PH_HALT} wbcw_phase_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_START, TGT_CMD, TGT_TIMER} wbcw_target_t;

  typedef struct packed {
    logic wrapErr;
    logic crcErr;
    logic deviceCodeMismatchFlag;
    logic watchdogExpiryFlag;
    logic warmBoot;
    logic fallback;
    logic valid;
  } wbcw_hist_t;
  typedef struct packed {
    wbcw_hist_t entry1;
    wbcw_hist_t entry0;
  } wbcw_boot_history_t;
  typedef struct packed {
    logic             userMonitorEnable;
    logic             configMonitorEnable;
    logic [WD_W-1:0]  value;
  } wbcw_timer_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } wbcw_word_t;
  typedef struct packed {
    logic startupDone;
    logic crcErr;
    logic idErr;
    logic wrapErr;
  } wbcw_result_t;
  typedef struct packed {
    logic [1:0]        revisionSelectPins;
    logic              revisionSelectOe;
    logic [ADDR_W-1:0] addr;
    logic              spiData;
    logic              spiActive;
  } wbcw_flash_t;
  typedef struct packed {
    wbcw_phase_t        phase;
    logic               synced;
    wbcw_target_t       target;
    logic [31:0]        warmBootStartAddress;
    wbcw_timer_t        timer;
    logic [WD_W-1:0]    wdCount;
    logic               wdOn;
    logic [TICK_W-1:0]  tickCnt;
    logic               fallback;
    logic               wdBlocked;
    logic               curWarm;
    wbcw_boot_history_t history;
    logic [15:0]        clearCnt;
    logic [4:0]         shiftCnt;
    logic [SPI_ADDR_W-1:0] shiftReg;
    wbcw_flash_t        flash;
    logic               initHigh;
    logic               doneHigh;
    logic               cfgResetPulse;
    logic               loadStartPulse;
  } wbcw_state_t;
endpackage : wbcw_pkg

//--- rtl/wbcw_loader.sv
`timescale 1ns/1ps
module wbcw_loader
  import wbcw_pkg::*;
#(
  parameter int CLEAR_CYCLES = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire wbcw_mode_t   cfgMode,
  input  wire wbcw_word_t   cmdWord,
  input  wire wbcw_result_t loadResult,
  input  wire logic         shutdown,
  output wbcw_flash_t        flashOut,
  output wbcw_boot_history_t bootHistoryStatus,
  output logic               initPin,
  output logic               donePin,
  output logic               cfgResetPulse,
  output logic               loadStartPulse,
  output logic               fallbackActive,
  output logic               watchdogEnabled,
  output logic [WD_W-1:0]    watchdogCount
);
  localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);
  localparam logic [4:0]  SHIFT_LAST = 5'(SPI_ADDR_W - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WD_TICK_CYCLES - 1);

  wbcw_state_t s;
  wbcw_state_t next_s;
  logic        warmGo;
  logic        fallbackGo;
  logic        histPush;
  logic        wdExpire;
  logic        wdTick;
  logic        wdActive;
  logic        warmReq;
  logic        reloadReq;
  logic        loadErr;
  wbcw_hist_t  newEntry;
  logic [5:0]  spiRun;
  logic [15:0] initLowRun;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.cfgResetPulse = 1'b0;
    next_s.loadStartPulse = 1'b0;
    warmGo = 1'b0;
    fallbackGo = 1'b0;
    histPush = 1'b0;
    warmReq = 1'b0;
    newEntry = '0;
    if (wdActive && wdTick && !reloadReq && s.wdCount != '0)
      next_s.wdCount = s.wdCount - 1'b1;

    // Command port: ignored while memory clears or after a halt
    if (cmdWord.valid && s.phase != PH_CLEAR && s.phase != PH_HALT)
    begin
      if (!s.synced)
      begin
        if (cmdWord.data == SYNC_WORD)  // [RL26]
          next_s.synced = 1'b1;
      end
      else
      begin
        case (s.target)
          TGT_NONE:
          begin
            if (cmdWord.data == HDR_START_ADDR)  // [RL5]
              next_s.target = TGT_START;
            else if (cmdWord.data == HDR_COMMAND)
              next_s.target = TGT_CMD;
            else if (cmdWord.data == HDR_TIMER)
              next_s.target = TGT_TIMER;
          end
          TGT_START:
          begin
            next_s.warmBootStartAddress = cmdWord.data;
            next_s.target = TGT_NONE;
          end
          TGT_TIMER:
          begin
            next_s.timer.userMonitorEnable = cmdWord.data[TMR_USR_BIT];
            next_s.timer.configMonitorEnable = cmdWord.data[TMR_CFG_BIT];
            next_s.timer.value = cmdWord.data[WD_W-1:0];
            next_s.wdCount = cmdWord.data[WD_W-1:0];  // [RL25]
            // A write re-arms only when fallback has not locked it out
            next_s.wdOn = !s.wdBlocked &&
                          (cmdWord.data[TMR_USR_BIT] || cmdWord.data[TMR_CFG_BIT]);  // [RL18]
            next_s.target = TGT_NONE;
          end
          TGT_CMD:
          begin
            next_s.target = TGT_NONE;
            if (cmdWord.data[3:0] == CMD_WARM_NIB)  // [RL6]
              warmReq = 1'b1;
            else if (cmdWord.data == CMD_RELEASE)
              next_s.synced = 1'b0;  // [RL26]
          end
          default:
            next_s.target = TGT_NONE;
        endcase
      end
    end
    if (reloadReq)
      next_s.wdCount = s.timer.value;  // [RL25]

    // ==========================================================
    // Watchdog, one tick per predivided configuration clock
    next_s.tickCnt = wdTick ? '0 : s.tickCnt + 1'b1;  // [RL16]
    if (shutdown)
      next_s.wdOn = 1'b0;  // [RL21]

    // ==========================================================
    // Warm boot; inside a fallback load it is only recorded
    if (warmReq)
    begin
      if (s.fallback && s.phase == PH_LOAD)
        next_s.curWarm = 1'b1;  // [RL11]
      else
      begin
        warmGo = 1'b1;
        if (s.phase == PH_LOAD)
        begin
          // Embedded command closes the load that carried it
          histPush = 1'b1;
          newEntry.valid = 1'b1;
          newEntry.warmBoot = s.curWarm;
          newEntry.fallback = s.fallback;
        end
        next_s.curWarm = 1'b1;
        next_s.fallback = 1'b0;
        next_s.flash.revisionSelectPins = s.warmBootStartAddress[RS_HI:RS_LO];  // [RL10]
        next_s.flash.revisionSelectOe = 1'b1;
      end
    end

    // An executed warm boot command wins over a load outcome in the same cycle
    if (s.phase == PH_LOAD && !warmGo && (loadErr || loadResult.startupDone))
    begin
      histPush = 1'b1;
      newEntry.valid = 1'b1;  // [RL13] [RL14]
      newEntry.wrapErr = loadResult.wrapErr;
      newEntry.crcErr = loadResult.crcErr;
      newEntry.deviceCodeMismatchFlag = loadResult.idErr;
      newEntry.watchdogExpiryFlag = wdExpire;  // [RL19]
      newEntry.warmBoot = next_s.curWarm;  // [RL15]
      newEntry.fallback = s.fallback;
      if (loadErr)
      begin
        if (s.fallback)
        begin
          next_s.phase = PH_HALT;  // [RL24]
          next_s.initHigh = 1'b0;
          next_s.doneHigh = 1'b0;
        end
        else
          fallbackGo = 1'b1;  // [RL17]
      end
      else
      begin
        next_s.phase = PH_RUN;
        next_s.doneHigh = 1'b1;
        next_s.flash.revisionSelectOe = 1'b0;
        if (s.curWarm && !s.fallback)
          next_s.wdBlocked = 1'b0;  // [RL18]
      end
    end
    if (s.phase == PH_RUN && wdExpire)
      fallbackGo = 1'b1;  // [RL17]

    if (fallbackGo)
    begin
      next_s.fallback = 1'b1;
      next_s.wdBlocked = 1'b1;  // [RL18]
      next_s.wdOn = 1'b0;
      next_s.curWarm = 1'b0;
      next_s.flash.revisionSelectPins = RS_FALLBACK;  // [RL23]
      next_s.flash.revisionSelectOe = 1'b1;
    end

    if (histPush)
    begin
      next_s.history.entry1 = s.history.entry0;  // [RL12]
      next_s.history.entry0 = newEntry;
    end

    // ==========================================================
    // Reconfiguration sequence; this block itself is not reset
    if (warmGo || fallbackGo)
    begin
      next_s.phase = PH_CLEAR;  // [RL1]
      next_s.cfgResetPulse = 1'b1;
      next_s.initHigh = 1'b0;  // [RL7]
      next_s.doneHigh = 1'b0;
      next_s.clearCnt = '0;
      next_s.synced = 1'b0;
      next_s.target = TGT_NONE;
    end
    else
    begin
      case (s.phase)
        PH_CLEAR:
        begin
          next_s.clearCnt = s.clearCnt + 1'b1;
          if (s.clearCnt == CLEAR_LAST)
          begin
            next_s.initHigh = 1'b1;  // [RL7]
            next_s.flash.addr = '0;
            next_s.shiftCnt = '0;
            next_s.shiftReg = '0;
            // Start location used only by the flash-addressed modes
            case (cfgMode)
              MODE_PAR_ASC:
                next_s.flash.addr = s.curWarm ?
                  s.warmBootStartAddress[ADDR_W-1:0] : ADDR_ASCEND;  // [RL2] [RL3] [RL8]
              MODE_PAR_DESC:
                next_s.flash.addr = s.curWarm ?
                  s.warmBootStartAddress[ADDR_W-1:0] : ADDR_DESCEND;  // [RL3]
              MODE_SPI:
                next_s.shiftReg = s.curWarm ?
                  s.warmBootStartAddress[SPI_ADDR_W-1:0] : '0;  // [RL9]
              default:
                next_s.flash.addr = '0;
            endcase
            if (cfgMode == MODE_SPI)
              next_s.phase = PH_SHIFT;
            else
            begin
              next_s.phase = PH_LOAD;
              next_s.loadStartPulse = 1'b1;
            end
          end
        end
        PH_SHIFT:
        begin
          next_s.shiftReg = {s.shiftReg[SPI_ADDR_W-2:0], 1'b0};  // [RL9]
          next_s.shiftCnt = s.shiftCnt + 1'b1;
          if (s.shiftCnt == SHIFT_LAST)
          begin
            next_s.phase = PH_LOAD;
            next_s.loadStartPulse = 1'b1;
          end
        end
        PH_LOAD, PH_RUN, PH_HALT:
          next_s.clearCnt = s.clearCnt;
        default:
          next_s.phase = PH_HALT;
      endcase
    end
    next_s.flash.spiActive = (next_s.phase == PH_SHIFT);
    next_s.flash.spiData = next_s.shiftReg[SPI_ADDR_W-1];
  end

  // Monitor choice: config mode watches a load, user mode a running image
  assign reloadReq = cmdWord.valid && s.phase != PH_CLEAR && s.phase != PH_HALT &&
                     s.synced && s.target == TGT_CMD && cmdWord.data == CMD_RELOAD;  // [RL6]
  assign wdTick = (s.tickCnt == TICK_LAST);
  assign wdActive = s.wdOn && !shutdown &&
                    ((s.timer.configMonitorEnable && s.phase == PH_LOAD) ||
                     (s.timer.userMonitorEnable && s.phase == PH_RUN));
  assign wdExpire = wdActive && wdTick && !reloadReq && s.wdCount == '0;  // [RL19]
  assign loadErr = loadResult.crcErr || loadResult.idErr ||
                   loadResult.wrapErr || (wdExpire && s.phase == PH_LOAD);

  // ==========================================================
  // State register; power-up starts a first load with pins released
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.phase <= PH_CLEAR;
      s.target <= TGT_NONE;
    end
    else
      s <= next_s;
  end

  assign flashOut = s.flash;
  assign bootHistoryStatus = s.history;
  assign initPin = s.initHigh;
  assign donePin = s.doneHigh;
  assign cfgResetPulse = s.cfgResetPulse;
  assign loadStartPulse = s.loadStartPulse;
  assign fallbackActive = s.fallback;
  assign watchdogEnabled = s.wdOn;
  assign watchdogCount = s.wdCount;

  // Run lengths for the checks below; long runs saturate instead of wrapping
  always_ff @(posedge clk)
  begin
    if (!rst_n || !flashOut.spiActive)
      spiRun <= '0;
    else if (spiRun != '1)
      spiRun <= spiRun + 1'b1;
    if (!rst_n || initPin)
      initLowRun <= '0;
    else if (initLowRun != '1)
      initLowRun <= initLowRun + 1'b1;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_warm_clears_pins: assert property (warmGo |=> s.phase == PH_CLEAR && !initPin && !donePin && cfgResetPulse)  // [RL7]
    else $error("warm boot did not start clearing");
  a_fallback_rs_zero: assert property (fallbackGo |=> flashOut.revisionSelectOe && flashOut.revisionSelectPins == RS_FALLBACK && s.fallback)  // [RL23]
    else $error("fallback did not drive select zero");
  a_warm_rs_drive: assert property (warmGo |=> flashOut.revisionSelectOe && flashOut.revisionSelectPins == $past(s.warmBootStartAddress[RS_HI:RS_LO]))  // [RL10]
    else $error("select pins not driven from start address");
  a_history_shift: assert property (histPush |=> bootHistoryStatus.entry1 == $past(bootHistoryStatus.entry0) && bootHistoryStatus.entry0.valid)  // [RL12]
    else $error("history did not shift");
  a_halt_pins_low: assert property (s.phase == PH_HALT |-> !initPin && !donePin)  // [RL24]
    else $error("halt without both pins low");
  a_ignored_warm_boot: assert property (warmReq && s.fallback && s.phase == PH_LOAD |=> s.curWarm && s.phase != PH_CLEAR)  // [RL11]
    else $error("warm boot executed during fallback");
  a_reload_restores: assert property (reloadReq |=> watchdogCount == $past(s.timer.value) && s.timer == $past(s.timer))  // [RL25]
    else $error("reload did not restore count");
  a_unsynced_ignored: assert property (!s.synced && cmdWord.valid && cmdWord.data == HDR_COMMAND |=> s.target == TGT_NONE)  // [RL26]
    else $error("header taken before sync");
  a_expire_fallback: assert property (wdExpire && !s.fallback |=> s.phase == PH_CLEAR && bootHistoryStatus.entry0.watchdogExpiryFlag == $past(s.phase == PH_LOAD))  // [RL17]
    else $error("expiry did not start fallback");
  a_spi_shift_len: assert property ($fell(flashOut.spiActive) && !cfgResetPulse |->  // [RL9]
                                    spiRun == 6'(SPI_ADDR_W))
    else $error("serial address not 24 bits");
  a_clear_then_init: assert property ($rose(initPin) |-> initLowRun >= 16'(CLEAR_CYCLES))  // [RL7]
    else $error("init released too early");

  c_warm_boot: cover property (warmGo ##[1:400] loadStartPulse);
  c_fallback_ok: cover property (fallbackGo ##[1:600] donePin);
  c_halt: cover property (s.phase == PH_HALT);
  c_reload: cover property (reloadReq);
endmodule : wbcw_loader

//--- testbench/wbcw_cmd_source.sv
`timescale 1ns/1ps
module wbcw_cmd_source
  import wbcw_pkg::*;
(
  input  wire logic clk,
  output wbcw_word_t cmdWord
);
  // ==================================================
  // Word source facing the command port
  initial cmdWord = '0;

  task automatic put(input logic [31:0] w);
    @(negedge clk);
    cmdWord.valid = 1'b1;
    cmdWord.data  = w;
  endtask : put

  // Data is inverted when idle so a stale word is never mistaken for a held one
  task automatic idle();
    @(negedge clk);
    cmdWord.valid = 1'b0;
    cmdWord.data  = ~cmdWord.data;
  endtask : idle

  task automatic syncUp();
    put(32'hffffffff);
    put(SYNC_WORD);
    put(32'h20000000);
  endtask : syncUp

  // One header, then exactly one data word
  task automatic write(input logic [31:0] hdr, input logic [31:0] w);
    put(hdr);
    put(w);
  endtask : write
endmodule : wbcw_cmd_source

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb
  import wbcw_pkg::*;
();
  localparam int CLR = 4;

  logic               clk;
  logic               rst_n;
  wbcw_mode_t         cfgMode;
  wbcw_word_t         cmdWord;
  wbcw_result_t       loadResult;
  logic               shutdown;
  wbcw_flash_t        flashOut;
  wbcw_boot_history_t hist;
  logic               initPin;
  logic               donePin;
  logic               cfgResetPulse;
  logic               loadStartPulse;
  logic               fallbackActive;
  logic               watchdogEnabled;
  logic [WD_W-1:0]    watchdogCount;
  int                 miscompares;
  int                 testsRun;
  logic [31:0]        adr;
  logic [WD_W-1:0]    tmo;
  bit                 seen;

  wbcw_loader #(.CLEAR_CYCLES(CLR)) u_dut (
    .clk               (clk),
    .rst_n             (rst_n),
    .cfgMode           (cfgMode),
    .cmdWord           (cmdWord),
    .loadResult        (loadResult),
    .shutdown          (shutdown),
    .flashOut          (flashOut),
    .bootHistoryStatus (hist),
    .initPin           (initPin),
    .donePin           (donePin),
    .cfgResetPulse     (cfgResetPulse),
    .loadStartPulse    (loadStartPulse),
    .fallbackActive    (fallbackActive),
    .watchdogEnabled   (watchdogEnabled),
    .watchdogCount     (watchdogCount)
  );

  wbcw_cmd_source u_src (
    .clk     (clk),
    .cmdWord (cmdWord)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==================================================
  // Helpers
  function automatic logic [6:0] entry(input logic crc, input logic wto, input logic warm,
                                       input logic fb);
    return {1'b0, crc, 1'b0, wto, warm, fb, 1'b1};
  endfunction : entry

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Looks at the current cycle first, since a one-cycle pulse may already stand
  task automatic waitFor(input int which, input int maxCyc, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < maxCyc; i++)
    begin
      if ((which == 0) ? (cfgResetPulse === 1'b1) : (loadStartPulse === 1'b1))
      begin
        hit = 1'b1;
        break;
      end
      @(negedge clk);
    end
  endtask : waitFor

  task automatic outcome(input logic [3:0] r);
    @(negedge clk);
    loadResult = r;
    @(negedge clk);
    loadResult = '0;
  endtask : outcome

  task automatic loadWait();
    waitFor(1, 60, seen);
    chk(32'({seen, initPin}), 32'h3);
  endtask : loadWait

  task automatic reboot(input wbcw_mode_t m, input logic [31:0] a);
    logic [SPI_ADDR_W-1:0] bits;
    cfgMode = m;
    u_src.syncUp();
    u_src.write(HDR_START_ADDR, a);
    u_src.write(HDR_COMMAND, {24'h0, 4'($urandom), CMD_WARM_NIB});
    u_src.idle();
    waitFor(0, 4, seen);
    chk(32'(seen), 1);
    @(negedge clk);
    chk(32'({initPin, donePin, flashOut.revisionSelectOe, flashOut.revisionSelectPins}),
        32'({3'b001, a[RS_HI:RS_LO]}));
    if (m == MODE_SPI)
    begin
      for (int i = 0; i < 40 && flashOut.spiActive !== 1'b1; i++)
        @(negedge clk);
      for (int i = SPI_ADDR_W - 1; i >= 0; i--)
      begin
        bits[i] = flashOut.spiData;
        @(negedge clk);
      end
      chk(32'(bits), 32'(a[SPI_ADDR_W-1:0]));
    end
    loadWait();
    if (m != MODE_SPI)
      chk(32'(flashOut.addr), 32'(a[ADDR_W-1:0]));
  endtask : reboot

  // A warm boot seen while the fallback image loads must only be recorded
  task automatic fallbackRun(input logic [ADDR_W-1:0] def, input logic [6:0] prev);
    loadWait();
    chk(32'(flashOut.addr), 32'(def));
    u_src.syncUp();
    u_src.write(HDR_COMMAND, {28'h0, CMD_WARM_NIB});
    u_src.idle();
    waitFor(0, 8, seen);
    chk(32'(seen), 0);
    outcome(4'b1000);
    chk(32'(hist), 32'({prev, entry(0, 0, 1, 1)}));
    u_src.syncUp();
    u_src.write(HDR_TIMER, {1'b0, 1'b1, 6'h0, 24'h10});
    u_src.idle();
    chk(32'(watchdogEnabled), 0);
  endtask : fallbackRun

  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ==================================================
  // Tests
  initial
  begin
    void'($urandom(44));
    miscompares = 0;
    testsRun = 0;
    rst_n = 1'b0;
    shutdown = 1'b0;
    loadResult = '0;
    cfgMode = MODE_PAR_ASC;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    loadWait();
    chk(32'(flashOut.addr), 32'(ADDR_ASCEND));
    outcome(4'b1000);
    chk(32'(hist), 32'({7'h0, entry(0, 0, 0, 0)}));
    chk(32'({donePin, flashOut.revisionSelectOe}), 32'h2);
    u_src.write(HDR_COMMAND, 32'hf);
    u_src.idle();
    waitFor(0, 8, seen);
    chk(32'(seen), 0);
    // User monitor: count, reload, release, shutdown
    u_src.syncUp();
    tmo = 24'(8 + $urandom_range(7));
    u_src.write(HDR_TIMER, {1'b1, 1'b0, 6'h0, tmo});
    u_src.idle();
    chk(32'({watchdogEnabled, watchdogCount}), 32'({1'b1, tmo}));
    repeat (3 * WD_TICK_CYCLES) @(negedge clk);
    chk(32'((tmo - watchdogCount) inside {24'd2, 24'd3}), 1);
    u_src.write(HDR_COMMAND, CMD_RELOAD);
    u_src.idle();
    chk(32'(watchdogCount), 32'(tmo));
    u_src.write(HDR_COMMAND, CMD_RELEASE);
    u_src.write(HDR_COMMAND, 32'hf);
    u_src.idle();
    waitFor(0, 8, seen);
    chk(32'(seen), 0);
    shutdown = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(watchdogEnabled), 0);
    shutdown = 1'b0;
    // Warm boot into serial flash mode
    adr = $urandom;
    reboot(MODE_SPI, adr);
    outcome(4'b1000);
    chk(32'(hist), 32'({entry(0, 0, 0, 0), entry(0, 0, 1, 0)}));
    // Config monitor expiry during a warm load
    tmo = 24'(1 + $urandom_range(3));
    u_src.syncUp();
    u_src.write(HDR_TIMER, {1'b0, 1'b1, 6'h0, tmo});
    u_src.idle();
    adr = $urandom;
    reboot(MODE_PAR_DESC, adr);
    waitFor(0, (int'(tmo) + 3) * WD_TICK_CYCLES, seen);
    chk(32'(seen), 1);
    @(negedge clk);
    chk(32'(hist), 32'({entry(0, 0, 1, 0), entry(0, 1, 1, 0)}));
    chk(32'({fallbackActive, watchdogEnabled, flashOut.revisionSelectOe,
             flashOut.revisionSelectPins}), 32'h14);
    fallbackRun(ADDR_DESCEND, entry(0, 1, 1, 0));
    // Warm image fails its checksum, fallback succeeds
    adr = $urandom;
    reboot(MODE_PAR_ASC, adr);
    outcome(4'b0100);
    waitFor(0, 4, seen);
    chk(32'(seen), 1);
    @(negedge clk);
    chk(32'(hist), 32'({entry(0, 0, 1, 1), entry(1, 0, 1, 0)}));
    fallbackRun(ADDR_ASCEND, entry(1, 0, 1, 0));
    // Fallback fails as well
    adr = $urandom;
    reboot(MODE_PAR_ASC, adr);
    outcome(4'b0100);
    loadWait();
    outcome(4'b0010);
    repeat (CLR + 8) @(negedge clk);
    chk(32'({initPin, donePin}), 0);
    results();
  end

  initial
  begin
    #800_000;
    miscompares++;
    results();
  end
endmodule : tb
